// *** verilog/copro_pkg.sv ***
package copro_pkg;
  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_INSTR = 8'h00;
  localparam logic [7:0] OFF_DISP = 8'h04;
  localparam logic [7:0] OFF_BXBP = 8'h08;
  localparam logic [7:0] OFF_SIDI = 8'h0c;
  localparam logic [7:0] OFF_OPERAND = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  localparam logic [7:0] OFF_RESULT = 8'h18;
  localparam logic [7:0] OFF_ADDR = 8'h1c;
  localparam logic [7:0] OFF_CONTROL = 8'h20;
  // status field positions
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_IRQEN_BIT = 1;
  localparam int ST_INVALID_BIT = 2;
  localparam int ST_UNSUP_BIT = 3;
  localparam int ST_TOP_LSB = 4;
  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] CONTROL_RESET = 16'h0000;
  localparam logic [2:0] TOP_RESET = 3'h0;
  // ----------------------------------------------------------------
  // opcode groups (11 bits after the escape prefix)
  // ----------------------------------------------------------------
  localparam logic [7:0] GRP_CONST = 8'b001_11_101;
  localparam logic [10:0] OP_SQRT = 11'b001_11_111_010;
  localparam logic [10:0] OP_SCALE = 11'b001_11_111_101;
  localparam logic [10:0] OP_PREM = 11'b001_11_111_000;
  localparam logic [10:0] OP_PTAN = 11'b001_11_110_010;
  localparam logic [10:0] OP_INIT = 11'b011_11_100_011;
  localparam logic [10:0] OP_IRQ_ON = 11'b011_11_100_000;
  localparam logic [10:0] OP_IRQ_OFF = 11'b011_11_100_001;
  localparam logic [5:0] MOP_LDCTL = 6'b001_101;
  localparam logic [5:0] MOP_STENV = 6'b001_110;
  localparam logic [5:0] MOP_LDENV = 6'b001_100;
  localparam logic [5:0] MOP_SAVE = 6'b101_110;
  localparam logic [1:0] MOD_REG = 2'b11;
  // constant patterns pushed by the load-constant group
  localparam logic [31:0] K_ZERO = 32'h00000000;
  localparam logic [31:0] K_ONE = 32'h3f800000;
  localparam logic [31:0] K_PI = 32'h40490fdb;
  localparam logic [31:0] K_L2T = 32'h40549a78;
  localparam logic [31:0] K_L2E = 32'h3fb8aa3b;
  localparam logic [31:0] K_LG2 = 32'h3e9a209b;
  localparam logic [31:0] K_LN2 = 32'h3f317218;
  // ----------------------------------------------------------------
  // cycle budgets (upper end of each range, lower end for CYC_PREM_MIN, in clocks)
  // ----------------------------------------------------------------
  localparam logic [11:0] CYC_LDZ = 12'd17;
  localparam logic [11:0] CYC_LD1 = 12'd21;
  localparam logic [11:0] CYC_LDPI = 12'd22;
  localparam logic [11:0] CYC_LDLG2 = 12'd24;
  localparam logic [11:0] CYC_LDLN2 = 12'd23;
  localparam logic [11:0] CYC_ADD_R = 12'd100;
  localparam logic [11:0] CYC_MUL_R = 12'd145;
  localparam logic [11:0] CYC_DIV_R = 12'd203;
  localparam logic [11:0] CYC_POP = 12'd5;
  localparam logic [47:0] CYC_ADD_M = {12'd137, 12'd125, 12'd143, 12'd120};
  localparam logic [47:0] CYC_MUL_M = {12'd138, 12'd168, 12'd144, 12'd125};
  localparam logic [47:0] CYC_DIV_M = {12'd238, 12'd230, 12'd243, 12'd225};
  localparam logic [11:0] CYC_SQRT = 12'd186;
  localparam logic [11:0] CYC_SCALE = 12'd38;
  localparam logic [11:0] CYC_PREM_MIN = 12'd15;
  localparam logic [11:0] CYC_PREM_MAX = 12'd190;
  localparam logic [11:0] CYC_PTAN = 12'd540;
  localparam logic [11:0] CYC_CTRL = 12'd8;
  localparam logic [11:0] CYC_LDCTL = 12'd14;
  localparam logic [11:0] CYC_STENV = 12'd50;
  localparam logic [11:0] CYC_LDENV = 12'd45;
  localparam logic [11:0] CYC_SAVE = 12'd207;
  localparam logic [11:0] CYC_OTHER = 12'd16;
  typedef enum logic [1:0] {S_IDLE = 2'b01, S_EXEC = 2'b10} state_t;
endpackage

// *** verilog/ea_unit.sv ***
`timescale 1ns/100ps
`default_nettype none
module addr_unit (
  input wire logic [1:0] mode, // addressing-mode field
  input wire logic [2:0] rm, // register/memory field
  input wire logic [15:0] disp_raw, // displacement bytes, low byte first
  input wire logic [15:0] bx, // base register
  input wire logic [15:0] bp, // base pointer
  input wire logic [15:0] si, // source index
  input wire logic [15:0] di, // destination index
  output logic [15:0] effective_address, // formed address
  output logic [1:0] disp_len // displacement bytes that follow
);
  import copro_pkg::*;
  // ----------------------------------------------------------------
  // displacement
  // ----------------------------------------------------------------
  wire logic [15:0] disp_sx = {{8{disp_raw[7]}}, disp_raw[7:0]};
  wire logic direct = (mode == 2'b00) && (rm == 3'b110);
  // length of the trailing displacement
  assign disp_len = (mode == 2'b01) ? 2'd1 :
    ((mode == 2'b10) || direct) ? 2'd2 : 2'd0;
  wire logic [15:0] disp = (mode == 2'b01) ? disp_sx :
    ((mode == 2'b10) || direct) ? disp_raw : 16'h0000;
  // ----------------------------------------------------------------
  // base and index selection
  // ----------------------------------------------------------------
  wire logic [15:0] base = rm[1] ? bp : bx;
  wire logic [15:0] index = rm[0] ? di : si;
  wire logic [15:0] single = (rm[1:0] == 2'b00) ? si : (rm[1:0] == 2'b01) ? di :
    (rm[1:0] == 2'b10) ? bp : bx;
  // wraps modulo 64k, as the segment offset does
  assign effective_address = direct ? disp :
    !rm[2] ? 16'(base + index + disp) : 16'(single + disp);
endmodule
`default_nettype wire

// *** verilog/copro_decoder.sv ***
`timescale 1ns/100ps
`default_nettype none
module copro_decoder #(
  parameter logic [11:0] ADDR_TIME = 12'd12, // address formation cycles
  parameter int DEPTH = 8 // register stack entries
) (
  input wire logic pclk, // clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  output logic busy, // busy to host test input
  output logic irq_enabled // interrupt request gate
);
  import copro_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  state_t state;
  logic [11:0] cnt;
  logic [10:0] op;
  logic [15:0] disp_raw;
  logic [15:0] bx, bp, si, di;
  logic [31:0] operand;
  logic [15:0] control;
  logic [15:0] addr_lat;
  logic [2:0] top;
  logic invalid, unsup;
  logic [31:0] stk [DEPTH];

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  wire logic setup = psel && !penable;
  wire logic access = psel && penable && pready;
  wire logic wr = access && pwrite;
  wire logic hit = (paddr[1:0] == 2'b00) && (paddr <= OFF_CONTROL);
  wire logic wr_instr = wr && (paddr == OFF_INSTR);
  // a launch while busy is refused and flagged as a slave error
  // the refusal flag from setup also blocks the launch, so a refused write never runs
  wire logic launch = wr_instr && (state == S_IDLE) && !pslverr;

  // ----------------------------------------------------------------
  // instruction fields
  // ----------------------------------------------------------------
  wire logic [1:0] fmt = op[10:9];
  wire logic [1:0] mode = op[7:6];
  wire logic [2:0] reg_f = op[5:3];
  wire logic [2:0] rm = op[2:0];
  wire logic reg_form = (mode == MOD_REG);
  wire logic dest_bit = op[10];
  wire logic pop_bit = op[9];
  wire logic arith_reg = reg_form && !op[8] && (reg_f[2] || !reg_f[1]);
  wire logic arith_mem = !reg_form && !op[8] && (reg_f[2] || !reg_f[1]);
  wire logic arith = arith_reg || arith_mem;
  wire logic is_const = (op[10:3] == GRP_CONST) && (rm != 3'b111);
  wire logic [5:0] mop = {op[10:8], reg_f};
  wire logic is_ldctl = !reg_form && (mop == MOP_LDCTL);
  wire logic is_stenv = !reg_form && (mop == MOP_STENV);
  wire logic is_ldenv = !reg_form && (mop == MOP_LDENV);
  wire logic is_save = !reg_form && (mop == MOP_SAVE);
  wire logic is_memctl = is_ldctl || is_stenv || is_ldenv || is_save;
  wire logic is_sqrt = (op == OP_SQRT);
  wire logic is_scale = (op == OP_SCALE);
  wire logic is_prem = (op == OP_PREM);
  wire logic is_ptan = (op == OP_PTAN);
  wire logic is_init = (op == OP_INIT);
  wire logic is_ctrl = is_init || (op == OP_IRQ_ON) || (op == OP_IRQ_OFF);

  // ----------------------------------------------------------------
  // address formation
  // ----------------------------------------------------------------
  logic [15:0] addr_now;
  addr_unit u_addr (
    .mode(mode),
    .rm(rm),
    .disp_raw(disp_raw),
    .bx(bx),
    .bp(bp),
    .si(si),
    .di(di),
    .effective_address(addr_now),
    .disp_len()
  );

  // ----------------------------------------------------------------
  // stack addressing, index relative to the current top
  // ----------------------------------------------------------------
  wire logic [2:0] p0 = top;
  wire logic [2:0] p1 = 3'(top + 3'd1);
  wire logic [2:0] pi_idx = 3'(top + rm);
  wire logic [2:0] push_idx = 3'(top - 3'd1);
  wire logic [31:0] st0 = stk[p0];
  wire logic [31:0] st1 = stk[p1];
  wire logic [31:0] sti = stk[pi_idx];

  // memory operand widened per format; 16-bit integer is sign-extended
  wire logic [31:0] mem_val = (fmt == 2'b11) ? {{16{operand[15]}}, operand[15:0]} :
    operand;

  // ----------------------------------------------------------------
  // arithmetic operand routing
  // ----------------------------------------------------------------
  wire logic to_sti = arith_reg && dest_bit;
  wire logic [31:0] dst_v = to_sti ? sti : st0;
  wire logic [31:0] src_v = arith_mem ? mem_val : (to_sti ? st0 : sti);
  // the printed reverse sense flips when the result goes to st(i)
  wire logic rev = reg_f[0] ^ (arith_reg && dest_bit);
  wire logic [31:0] lhs = rev ? src_v : dst_v;
  wire logic [31:0] rhs = rev ? dst_v : src_v;
  wire logic div_zero = reg_f[2] && reg_f[1] && (rhs == 32'h0);
  wire logic [31:0] prod = 32'(lhs * rhs);
  wire logic [31:0] quot = div_zero ? 32'h0 : 32'($signed(lhs) / $signed(rhs));
  wire logic [31:0] arith_res = !reg_f[2] ? (reg_f[0] ? prod : 32'(lhs + rhs)) :
    (reg_f[1] ? quot : 32'(lhs - rhs));
  wire logic [2:0] dst_idx = to_sti ? pi_idx : p0;

  // ----------------------------------------------------------------
  // constant select
  // ----------------------------------------------------------------
  wire logic [31:0] k_val = (rm == 3'b110) ? K_ZERO : (rm == 3'b000) ? K_ONE :
    (rm == 3'b011) ? K_PI : (rm == 3'b001) ? K_L2T : (rm == 3'b010) ? K_L2E :
    (rm == 3'b100) ? K_LG2 : K_LN2;
  wire logic [11:0] k_cyc = (rm == 3'b110) ? CYC_LDZ : (rm == 3'b011) ? CYC_LDPI :
    (rm == 3'b001) ? CYC_LDPI : (rm == 3'b100) ? CYC_LDLG2 :
    (rm == 3'b101) ? CYC_LDLN2 : CYC_LD1;

  // ----------------------------------------------------------------
  // special functions
  // ----------------------------------------------------------------
  wire logic sqrt_bad = st0[31] && (st0[30:0] != 31'h0);
  wire logic scale_ok = ($signed(st1) >= -32'sd32768) && ($signed(st1) < 32'sd32768);
  wire logic [31:0] scaled = st1[31] ? 32'($signed(st0) >>> 5'(-st1)) :
    32'(st0 << st1[4:0]);
  wire logic [31:0] rem = (st1 == 32'h0) ? st0 : 32'(st0 % st1);
  // remainder time grows with the spread between the two magnitudes
  wire logic [5:0] lz0 = 6'($clog2(st0 + 32'h1));
  wire logic [5:0] lz1 = 6'($clog2(st1 + 32'h1));
  wire logic [11:0] prem_span = (lz0 > lz1) ? {6'h0, 6'(lz0 - lz1)} : 12'h0;
  wire logic [11:0] prem_try = 12'(CYC_PREM_MIN + 12'(prem_span * 12'd5));
  wire logic [11:0] prem_cyc = (prem_try > CYC_PREM_MAX) ? CYC_PREM_MAX : prem_try;

  // ----------------------------------------------------------------
  // cycle budget of the latched instruction
  // ----------------------------------------------------------------
  // lane offset of the format in the packed budgets; six bits so format 11 reaches 36
  wire logic [5:0] fsel = 6'(fmt) * 6'd12;
  wire logic [11:0] add_m = CYC_ADD_M[fsel +: 12];
  wire logic [11:0] mul_m = CYC_MUL_M[fsel +: 12];
  wire logic [11:0] div_m = CYC_DIV_M[fsel +: 12];
  wire logic [11:0] ar_base = !reg_f[2] ? (reg_f[0] ? CYC_MUL_R : CYC_ADD_R) :
    (reg_f[1] ? CYC_DIV_R : CYC_ADD_R);
  wire logic [11:0] am_base = !reg_f[2] ? (reg_f[0] ? mul_m : add_m) :
    (reg_f[1] ? div_m : add_m);
  wire logic [11:0] ar_cyc = 12'(ar_base + (pop_bit ? CYC_POP : 12'h0));
  wire logic [11:0] mc_base = is_ldctl ? CYC_LDCTL : is_stenv ? CYC_STENV :
    is_ldenv ? CYC_LDENV : CYC_SAVE;
  wire logic [11:0] budget = arith_reg ? ar_cyc :
    arith_mem ? 12'(am_base + ADDR_TIME) :
    is_memctl ? 12'(mc_base + ADDR_TIME) :
    is_const ? k_cyc :
    is_sqrt ? CYC_SQRT :
    is_scale ? CYC_SCALE :
    is_prem ? prem_cyc :
    is_ptan ? CYC_PTAN :
    is_ctrl ? CYC_CTRL : CYC_OTHER;

  // ----------------------------------------------------------------
  // sequencer: latch, count, then commit
  // ----------------------------------------------------------------
  wire logic done = (state == S_EXEC) && (cnt == 12'd1);
  logic loaded; // budget is taken one cycle after the launch latches the opcode
  wire logic known = arith || is_const || is_memctl || is_sqrt || is_scale ||
    is_prem || is_ptan || is_ctrl;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= S_IDLE;
      cnt <= 12'h0;
      loaded <= 1'b0;
    end else begin
      case (state)
        S_IDLE: begin
          if (launch) begin
            state <= S_EXEC;
            loaded <= 1'b0;
          end
        end
        S_EXEC: begin
          if (!loaded) begin
            cnt <= budget;
            loaded <= 1'b1;
          end else if (done) begin
            state <= S_IDLE;
          end else begin
            cnt <= 12'(cnt - 12'd1);
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // busy is raised with the launch and dropped with the commit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy <= 1'b0;
    end else begin
      busy <= (launch || (state == S_EXEC)) && !(loaded && done);
    end
  end

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op <= 11'h0;
      disp_raw <= 16'h0;
      {bx, bp, si, di} <= 64'h0;
      operand <= 32'h0;
    end else if (wr) begin
      if (launch) op <= pwdata[10:0];
      if (paddr == OFF_DISP) disp_raw <= pwdata[15:0];
      if (paddr == OFF_BXBP) {bp, bx} <= pwdata;
      if (paddr == OFF_SIDI) {di, si} <= pwdata;
      if (paddr == OFF_OPERAND) operand <= pwdata;
    end
  end

  // address is caught when the budget loads, from the latched fields
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_lat <= 16'h0;
    end else if ((state == S_EXEC) && !loaded && !reg_form) begin
      addr_lat <= addr_now;
    end
  end

  // ----------------------------------------------------------------
  // commit of results, stack and flags
  // ----------------------------------------------------------------
  wire logic commit = loaded && done;
  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : g_stk
      wire logic [2:0] me = 3'(g);
      wire logic wr_ar = arith && (dst_idx == me);
      wire logic wr_k = is_const && (push_idx == me);
      wire logic wr_sp = (is_sqrt || is_scale || is_prem) && (p0 == me);
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          stk[g] <= 32'h0;
        end else if (commit) begin
          if (wr_ar) stk[g] <= arith_res;
          else if (wr_k) stk[g] <= k_val;
          else if (wr_sp && is_scale && scale_ok) stk[g] <= scaled;
          else if (wr_sp && is_prem) stk[g] <= rem;
          else if (wr_sp && is_sqrt && !sqrt_bad) stk[g] <= st0;
        end
      end
    end
  endgenerate

  // top pointer moves only at the commit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      top <= TOP_RESET;
    end else if (commit) begin
      if (is_init) top <= TOP_RESET;
      else if (is_const) top <= push_idx;
      else if (arith_reg && pop_bit) top <= p1;
    end
  end

  // control word, gate and sticky error flags; only init clears the error flags, irq off also clears the gate
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control <= CONTROL_RESET;
      irq_enabled <= 1'b0;
      invalid <= 1'b0;
      unsup <= 1'b0;
    end else if (commit) begin
      if (is_init) begin
        control <= CONTROL_RESET;
        irq_enabled <= 1'b0;
        invalid <= 1'b0;
        unsup <= 1'b0;
      end else begin
        if (is_ldctl || is_ldenv) control <= operand[15:0];
        if (op == OP_IRQ_ON) irq_enabled <= 1'b1;
        if (op == OP_IRQ_OFF) irq_enabled <= 1'b0;
        if ((arith && div_zero) || (is_scale && !scale_ok) ||
            (is_sqrt && sqrt_bad) || (is_prem && (st1 == 32'h0)) ||
            (is_ptan && st0[31])) invalid <= 1'b1;
        if (!known) unsup <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // read mux and registered apb answer
  // ----------------------------------------------------------------
  wire logic [31:0] status = {24'h0, 1'b0, top, unsup, invalid, irq_enabled, busy};
  wire logic [31:0] rd_mux = (paddr == OFF_INSTR) ? {21'h0, op} :
    (paddr == OFF_DISP) ? {16'h0, disp_raw} :
    (paddr == OFF_BXBP) ? {bp, bx} :
    (paddr == OFF_SIDI) ? {di, si} :
    (paddr == OFF_OPERAND) ? operand :
    (paddr == OFF_STATUS) ? status :
    (paddr == OFF_RESULT) ? st0 :
    (paddr == OFF_ADDR) ? {16'h0, addr_lat} :
    (paddr == OFF_CONTROL) ? {16'h0, control} : 32'h0;
  wire logic err_now = !hit || (pwrite && (paddr == OFF_INSTR) && (state != S_IDLE)) ||
    (pwrite && (paddr >= OFF_STATUS) && (paddr != OFF_CONTROL)) ||
    (pwrite && (paddr == OFF_CONTROL));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= setup;
      pslverr <= setup && err_now;
      if (setup && !pwrite) prdata <= rd_mux;
    end
  end
endmodule
`default_nettype wire

// *** dv/host_wait_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module host_wait_model (
  input wire logic pclk, // clock
  input wire logic presetn, // reset, active low
  input wire logic busy, // test input
  output logic done // host past its wait loop
);
  logic [2:0] gap;
  // ------------------------------------------------
  // host wait loop: first look after 3 clocks, then every 5
  // ------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done <= 1'b1;
      gap <= 3'h0;
    end else if (done && busy) begin
      done <= 1'b0;
      gap <= 3'h2;
    end else if (!done && gap != 3'h0) begin
      gap <= gap - 3'h1;
    end else if (!done) begin
      done <= !busy;
      gap <= 3'h4;
    end
  end
endmodule
`default_nettype wire

// *** dv/copro_chk.sv ***
`timescale 1ns/100ps
`default_nettype none
module copro_chk
  import copro_pkg::*;
(
  input wire logic pclk, // clock
  input wire logic presetn, // reset
  input wire logic psel, // apb
  input wire logic penable, // apb
  input wire logic pwrite, // apb
  input wire logic [7:0] paddr, // apb
  input wire logic [31:0] pwdata, // apb
  input wire logic [31:0] prdata, // apb
  input wire logic pready, // apb
  input wire logic pslverr, // apb
  input wire logic busy, // busy out
  input wire logic irq_enabled // irq gate
);
  // ------------------------------------------------
  // accepted instruction writes
  // ------------------------------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc = psel && penable && pready && pwrite && paddr == OFF_INSTR && !pslverr;
  wire [10:0] op = pwdata[10:0];
  a_busy_start: assert property (acc |=> busy)
    else $error("busy not raised");
  a_busy_hold: assert property ($rose(busy) |-> busy[*8])
    else $error("busy dropped early");
  a_refuse_busy: assert property (psel && penable && pready && pwrite && paddr == OFF_INSTR
    && busy |-> pslverr)
    else $error("write while busy taken");
  a_irq_on: assert property (acc && op == OP_IRQ_ON |=>
    busy[*8] ##1 busy ##1 !busy && irq_enabled)
    else $error("enable timing");
  a_irq_off: assert property (acc && op == OP_IRQ_OFF |=>
    busy[*8] ##1 busy ##1 !busy && !irq_enabled)
    else $error("disable timing");
  a_init_time: assert property (acc && op == OP_INIT |=>
    busy[*8] ##1 busy ##1 !busy && !irq_enabled)
    else $error("init timing");
  a_sqrt_time: assert property (acc && op == OP_SQRT |-> ##187 busy ##1 !busy)
    else $error("sqrt timing");
  a_zero_time: assert property (acc && op == {GRP_CONST, 3'h6} |-> ##18 busy ##1 !busy)
    else $error("zero load timing");
  a_pop_time: assert property (acc && op[9:3] == 7'b1011000 |-> ##106 busy ##1 !busy)
    else $error("pop add timing");
  a_ready_one: assert property (pready |=> !pready)
    else $error("ready too long");
endmodule
bind copro_decoder copro_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .busy, .irq_enabled);
`default_nettype wire

// *** dv/tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import copro_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata, rd;
  logic pready, pslverr, busy, irq_enabled, done, err;
  int mismatches = 0;
  int check_count = 0;
  logic [2:0] rms [7] = '{3'h6, 3'h0, 3'h3, 3'h1, 3'h2, 3'h4, 3'h5};
  int cyc [7] = '{17, 21, 22, 22, 21, 24, 23};
  logic [31:0] ks [7] = '{K_ZERO, K_ONE, K_PI, K_L2T, K_L2E, K_LG2, K_LN2};
  logic [10:0] ops [3] = '{11'b000_10_000_000, 11'b000_01_000_111, 11'b000_00_000_110};
  logic [31:0] ds [3] = '{32'h34, 32'h80, 32'h5678};
  logic [31:0] eas [3] = '{32'h1234, 32'h0f80, 32'h5678};
  always #5 pclk = ~pclk;
  copro_decoder dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .busy, .irq_enabled);
  host_wait_model host (.pclk, .presetn, .busy, .done);
  // ------------------------------------------------
  // bus and check tasks
  // ------------------------------------------------
  task automatic close_out;
    if (mismatches == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // zero wait states expected, but never assumed
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      mismatches++;
      close_out();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask
  // counts busy cycles after the accepting edge, then lets the host poll
  task automatic wait_idle(input int e);
    int n;
    n = 0;
    #1;
    while (busy === 1'b1 && n < 5000) begin
      n++;
      @(posedge pclk);
      #1;
    end
    if (n >= 5000) begin
      mismatches++;
      close_out();
    end
    chk("busy cycles", e, n);
    repeat (6) @(posedge pclk);
    chk("host done", 1, {31'h0, done});
  endtask
  task automatic run(input logic [10:0] op, input int e);
    apb(1'b1, OFF_INSTR, {21'h0, op});
    wait_idle(e);
  endtask
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rdchk("status", OFF_STATUS, 32'h0);
    apb(1'b1, OFF_STATUS, 32'hf);
    chk("ro write err", 1, {31'h0, err});
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped err", 1, {31'h0, err});
    for (int i = 0; i < 7; i++) begin
      run({GRP_CONST, rms[i]}, cyc[i] + 1);
      rdchk("constant", OFF_RESULT, ks[i]);
    end
    rdchk("top", OFF_STATUS, 32'h10);
    apb(1'b1, OFF_BXBP, 32'h1000);
    apb(1'b1, OFF_SIDI, 32'h0200);
    apb(1'b1, OFF_OPERAND, 32'h10);
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, OFF_DISP, ds[i]);
      run(ops[i], 133);
      rdchk("addr", OFF_ADDR, eas[i]);
      rdchk("sum", OFF_RESULT, 32'h3f317228 + 32'(i) * 32'h10);
    end
    run(11'b110_11_000_001, 106);
    rdchk("pop sum", OFF_RESULT, 32'h7dcb92e3);
    rdchk("pop top", OFF_STATUS, 32'h20);
    apb(1'b1, OFF_OPERAND, 32'h0001fff0);
    run(11'b110_10_000_000, 150);
    rdchk("addr 16 int", OFF_ADDR, 32'h6878);
    rdchk("sum 16 int", OFF_RESULT, 32'h7dcb92d3);
    run(11'b001_00_101_110, 27);
    rdchk("control", OFF_CONTROL, 32'hfff0);
    run(11'b000_00_110_110, 238);
    rdchk("quotient", OFF_RESULT, 32'h3ee7);
    run(OP_SCALE, 39);
    rdchk("scale refused", OFF_STATUS, 32'h24);
    run(OP_IRQ_ON, 9);
    chk("irq on", 1, {31'h0, irq_enabled});
    run(OP_IRQ_OFF, 9);
    chk("irq off", 0, {31'h0, irq_enabled});
    run(OP_IRQ_ON, 9);
    apb(1'b1, OFF_INSTR, {21'h0, OP_SQRT});
    apb(1'b1, OFF_INSTR, {21'h0, OP_INIT});
    chk("busy refusal", 1, {31'h0, err});
    wait_idle(184);
    run(OP_INIT, 9);
    rdchk("init status", OFF_STATUS, 32'h0);
    run(OP_PTAN, 541);
    rdchk("tangent status", OFF_STATUS, 32'h0);
    close_out();
  end
endmodule
`default_nettype wire
